// [rtl/hcw_ctl.sv]
//------------------------------------------------------------
// Purpose: Code word and HDLC channel control bank for two framers
// Assumes: Control port strobes already in the system clock domain
// Notes:   Read data is registered, valid the cycle after the read pulse
//------------------------------------------------------------
module hcw_ctl
	import hcw_pkg::*;
#(
	parameter int FIFO_DEPTH = HCW_FIFO_DEPTH
) (
	input  wire logic        sys_clk_in,          // System clock, 10 MHz
	input  wire logic        rst_n_in,            // Async reset, active low
	input  wire logic [7:0]  bus_addr_in,         // Control port address
	input  wire logic        bus_wr_in,           // Write pulse
	input  wire logic        bus_rd_in,           // Read pulse
	input  wire logic [7:0]  bus_wdata_in,        // Write data
	output logic      [7:0]  bus_rdata_out,       // Read data, registered
	input  wire logic [1:0]  tx_link_input_pin_in,// External link pins, async
	input  wire logic [1:0]  hdlc_fdl_bit_in,     // On-chip HDLC link bits
	input  wire logic [1:0]  fifo_pop_in,         // HDLC controller byte takes
	output logic      [15:0] fifo_data_out,       // Popped bytes, B in upper
	output logic      [1:0]  fifo_empty_out,      // FIFO empty per framer
	output logic      [1:0]  fdl_bit_out,         // Selected link bit
	output logic      [1:0]  send_code_word_out,  // Code word start pulse
	output logic      [11:0] code_word_out,       // Code words, B in upper
	output logic      [1:0]  rx_channel_enable_out,      // Rx HDLC on channels
	output logic      [1:0]  rx_channel_select_mode_out, // Rx block mode
	output logic      [9:0]  rx_chan_sel_out,     // Rx single channel, B upper
	output logic      [15:0] rx_bit_suppress_out  // Rx bit suppress, B upper
);

	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------
	function automatic logic hit(input logic [7:0] addr, input logic [7:0] off_a,
		input logic [7:0] off_b, input int frm);
		hit = (addr == ((frm == 0) ? off_a : off_b));
	endfunction : hit

	logic [1:0] wr_code;
	logic [1:0] wr_fifo;
	logic [1:0] wr_rdc1;
	logic [1:0] wr_rdc2;
	logic [1:0] rd_stat;
	logic [7:0] code_ctl [2];
	logic [7:0] rdc1     [2];
	logic [7:0] rdc2     [2];
	logic [2:0] status   [2];
	logic [1:0] link_meta_r;
	logic [1:0] link_sync_r;
	logic [7:0] rdata_nxt;

	// ------------------------------------------------------------
	// Per-framer blocks
	// ------------------------------------------------------------
	for (genvar f = 0; f < HCW_FRAMERS; f++) begin : g_frm
		assign wr_code[f] = bus_wr_in && hit(bus_addr_in, HCW_CODE_A_OFF, HCW_CODE_B_OFF, f);
		assign wr_fifo[f] = bus_wr_in && hit(bus_addr_in, HCW_FIFO_A_OFF, HCW_FIFO_B_OFF, f);
		assign wr_rdc1[f] = bus_wr_in && hit(bus_addr_in, HCW_RDC1_A_OFF, HCW_RDC1_B_OFF, f);
		assign wr_rdc2[f] = bus_wr_in && hit(bus_addr_in, HCW_RDC2_A_OFF, HCW_RDC2_B_OFF, f);
		assign rd_stat[f] = bus_rd_in && hit(bus_addr_in, HCW_STAT_A_OFF, HCW_STAT_B_OFF, f);

		hcw_framer #(
			.DEPTH          (FIFO_DEPTH)
		) u_frm (
			.sys_clk_in     (sys_clk_in),
			.rst_n_in       (rst_n_in),
			.wr_code_in     (wr_code[f]),
			.wr_fifo_in     (wr_fifo[f]),
			.wr_rdc1_in     (wr_rdc1[f]),
			.wr_rdc2_in     (wr_rdc2[f]),
			.rd_stat_in     (rd_stat[f]),
			.wdata_in       (bus_wdata_in),
			.fifo_pop_in    (fifo_pop_in[f]),
			.code_ctl_out   (code_ctl[f]),
			.rdc1_out       (rdc1[f]),
			.rdc2_out       (rdc2[f]),
			.status_out     (status[f]),
			.fifo_data_out  (fifo_data_out[f*8 +: 8]),
			.send_start_out (send_code_word_out[f])
		);

		assign fifo_empty_out[f] = status[f][HCW_ST_EMPTY_BIT];
		assign code_word_out[f*HCW_CODE_W +: HCW_CODE_W] =
			code_ctl[f][HCW_CODE_LSB +: HCW_CODE_W];
		assign rx_channel_enable_out[f]      = rdc1[f][HCW_RX_EN_BIT];
		assign rx_channel_select_mode_out[f] = rdc1[f][HCW_RX_MODE_BIT];
		assign rx_chan_sel_out[f*HCW_RX_SEL_W +: HCW_RX_SEL_W] =
			rdc1[f][HCW_RX_SEL_LSB +: HCW_RX_SEL_W];
		assign rx_bit_suppress_out[f*8 +: 8] = rdc2[f];
	end

	// ------------------------------------------------------------
	// Link source selection
	// ------------------------------------------------------------
	// Link pins are asynchronous; two stages before any use
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			link_meta_r <= 2'b00;
			link_sync_r <= 2'b00;
		end else begin
			link_meta_r <= tx_link_input_pin_in;
			link_sync_r <= link_meta_r;
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			fdl_bit_out <= 2'b00;
		else
			for (int f = 0; f < HCW_FRAMERS; f++)
				fdl_bit_out[f] <= code_ctl[f][HCW_SRC_BIT] ?
					hdlc_fdl_bit_in[f] : link_sync_r[f];
	end

	// ------------------------------------------------------------
	// Read back
	// ------------------------------------------------------------
	// Data register is write only and unmapped reads give zero
	always_comb begin
		rdata_nxt = 8'h00;
		for (int f = 0; f < HCW_FRAMERS; f++) begin
			if (hit(bus_addr_in, HCW_CODE_A_OFF, HCW_CODE_B_OFF, f))
				rdata_nxt = code_ctl[f];
			if (hit(bus_addr_in, HCW_RDC1_A_OFF, HCW_RDC1_B_OFF, f))
				rdata_nxt = rdc1[f];
			if (hit(bus_addr_in, HCW_RDC2_A_OFF, HCW_RDC2_B_OFF, f))
				rdata_nxt = rdc2[f];
			if (hit(bus_addr_in, HCW_STAT_A_OFF, HCW_STAT_B_OFF, f))
				rdata_nxt = {5'h00, status[f]};
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			bus_rdata_out <= HCW_RDATA_RST;
		else if (bus_rd_in)
			bus_rdata_out <= rdata_nxt;
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	a_src_pin_path: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		(!code_ctl[0][HCW_SRC_BIT] && $stable(code_ctl[0])) |=>
			(fdl_bit_out[0] == $past(link_sync_r[0])))
		else $error("link bit not taken from pin with source bit low");
	a_src_hdlc_path: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		code_ctl[1][HCW_SRC_BIT] |=> (fdl_bit_out[1] == $past(hdlc_fdl_bit_in[1])))
		else $error("link bit not taken from HDLC with source bit high");
	a_code_start_edge: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		send_code_word_out[0] |-> (code_ctl[0][HCW_SEND_BIT]
			&& !$past(code_ctl[0][HCW_SEND_BIT])))
		else $error("code word start without a rising send bit");
	a_code_word_value: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		wr_code[0] |=> (code_word_out[5:0] == $past(bus_wdata_in[5:0])))
		else $error("code word field not written");
	a_rx_chan_select: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		wr_rdc1[1] |=> (rx_chan_sel_out[9:5] == $past(bus_wdata_in[4:0])))
		else $error("rx channel select not taken from bits four to zero");
	a_rx_route: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		wr_rdc1[0] |=> (rx_channel_enable_out[0] == $past(bus_wdata_in[7]))
			&& (rx_channel_select_mode_out[0] == $past(bus_wdata_in[5])))
		else $error("rx routing bits not taken from control write");
	a_udr_read_clear: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		(rd_stat[0] && !fifo_pop_in[0]) |=>
			!status[0][HCW_ST_UDR_BIT])
		else $error("underrun flag not cleared by status read");
	a_full_readback: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		rd_stat[1] |=> (bus_rdata_out[HCW_ST_FULL_BIT] == $past(status[1][HCW_ST_FULL_BIT])))
		else $error("full flag read back wrong");

	// ------------------------------------------------------------
	// Per-framer checks
	// ------------------------------------------------------------
	// Both framers get these; the labelled checks above watch one framer each
	for (genvar f = 0; f < HCW_FRAMERS; f++) begin : g_chk
		a_send_on_rise: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
			(wr_code[f] && bus_wdata_in[HCW_SEND_BIT] && !code_ctl[f][HCW_SEND_BIT])
				|=> send_code_word_out[f])
			else $error("rising send bit gave no code word start");
		a_send_no_repeat: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
			code_ctl[f][HCW_SEND_BIT] |=> !send_code_word_out[f])
			else $error("code word start while send bit already set");
		a_pin_source: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
			!code_ctl[f][HCW_SRC_BIT] |=> (fdl_bit_out[f] == $past(link_sync_r[f])))
			else $error("link bit not taken from pin with source bit low");
		a_hdlc_source: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
			code_ctl[f][HCW_SRC_BIT] |=> (fdl_bit_out[f] == $past(hdlc_fdl_bit_in[f])))
			else $error("link bit not taken from HDLC with source bit high");
		a_chan_sel_write: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
			wr_rdc1[f] |=> (rx_chan_sel_out[f*HCW_RX_SEL_W +: HCW_RX_SEL_W]
				== $past(bus_wdata_in[4:0])))
			else $error("rx channel select not taken from bits four to zero");
		a_route_write: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
			wr_rdc1[f] |=> (rx_channel_enable_out[f] == $past(bus_wdata_in[HCW_RX_EN_BIT]))
				&& (rx_channel_select_mode_out[f] == $past(bus_wdata_in[HCW_RX_MODE_BIT])))
			else $error("rx routing bits not taken from control write");
		a_underrun_clear: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
			(rd_stat[f] && !fifo_pop_in[f]) |=> !status[f][HCW_ST_UDR_BIT])
			else $error("underrun flag not cleared by status read");
		a_underrun_report: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
			(rd_stat[f] && status[f][HCW_ST_UDR_BIT]) |=> bus_rdata_out[HCW_ST_UDR_BIT])
			else $error("set underrun flag read back low");
		a_full_report: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
			rd_stat[f] |=> (bus_rdata_out[HCW_ST_FULL_BIT] == $past(status[f][HCW_ST_FULL_BIT])))
			else $error("full flag read back wrong");
		a_status_top_zero: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
			rd_stat[f] |=> (bus_rdata_out[7:3] == 5'h00))
			else $error("unused status bits read back nonzero");
	end

	c_code_sent: cover property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		send_code_word_out[1]);
	c_udr_cleared: cover property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		status[0][HCW_ST_UDR_BIT] ##1 rd_stat[0] ##1 !status[0][HCW_ST_UDR_BIT]);
	c_hdlc_source: cover property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		code_ctl[0][HCW_SRC_BIT] && rx_channel_enable_out[0]);
	c_pin_source: cover property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		!code_ctl[1][HCW_SRC_BIT] && fdl_bit_out[1]);
endmodule : hcw_ctl

// [rtl/hcw_pkg.sv]
//------------------------------------------------------------
// Purpose: Constants for the code word and HDLC channel control bank
// Assumes: Byte-wide parallel control port, two framers A and B
// Notes:   Offsets are byte addresses on the control port
//------------------------------------------------------------
package hcw_pkg;
	localparam int         HCW_FRAMERS      = 2;
	localparam int         HCW_FIFO_DEPTH   = 64;
	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] HCW_STAT_A_OFF   = 8'h06;
	localparam logic [7:0] HCW_STAT_B_OFF   = 8'ha6;
	localparam logic [7:0] HCW_CODE_A_OFF   = 8'h07;
	localparam logic [7:0] HCW_CODE_B_OFF   = 8'ha7;
	localparam logic [7:0] HCW_FIFO_A_OFF   = 8'h08;
	localparam logic [7:0] HCW_FIFO_B_OFF   = 8'ha8;
	localparam logic [7:0] HCW_RDC1_A_OFF   = 8'h90;
	localparam logic [7:0] HCW_RDC1_B_OFF   = 8'h94;
	localparam logic [7:0] HCW_RDC2_A_OFF   = 8'h91;
	localparam logic [7:0] HCW_RDC2_B_OFF   = 8'h95;
	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int         HCW_SEND_BIT     = 7;
	localparam int         HCW_SRC_BIT      = 6;
	localparam int         HCW_CODE_LSB     = 0;
	localparam int         HCW_CODE_W       = 6;
	localparam int         HCW_RX_EN_BIT    = 7;
	localparam int         HCW_RX_MODE_BIT  = 5;
	localparam int         HCW_RX_SEL_LSB   = 0;
	localparam int         HCW_RX_SEL_W     = 5;
	localparam int         HCW_ST_UDR_BIT   = 0;
	localparam int         HCW_ST_FULL_BIT  = 1;
	localparam int         HCW_ST_EMPTY_BIT = 2;
	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [7:0] HCW_CODE_RST     = 8'h00;
	localparam logic [7:0] HCW_RDC1_RST     = 8'h00;
	localparam logic [7:0] HCW_RDC2_RST     = 8'h00;
	localparam logic [7:0] HCW_RDATA_RST    = 8'h00;
endpackage : hcw_pkg

// [rtl/hcw_framer.sv]
//------------------------------------------------------------
// Purpose: One framer's registers, transmit FIFO and code word trigger
// Assumes: Strobes are one-cycle pulses decoded by the parent
// Notes:   FIFO is flip-flops; drained by the transmit HDLC controller
//------------------------------------------------------------
module hcw_framer
	import hcw_pkg::*;
#(
	parameter int DEPTH = HCW_FIFO_DEPTH
) (
	input  wire logic        sys_clk_in,       // System clock
	input  wire logic        rst_n_in,         // Async reset, active low
	input  wire logic        wr_code_in,       // Write code word control
	input  wire logic        wr_fifo_in,       // Write transmit FIFO byte
	input  wire logic        wr_rdc1_in,       // Write rx channel control 1
	input  wire logic        wr_rdc2_in,       // Write rx channel control 2
	input  wire logic        rd_stat_in,       // Status read pulse
	input  wire logic [7:0]  wdata_in,         // Write data
	input  wire logic        fifo_pop_in,      // HDLC controller takes a byte
	output logic      [7:0]  code_ctl_out,     // Code word control register
	output logic      [7:0]  rdc1_out,         // Rx channel control 1
	output logic      [7:0]  rdc2_out,         // Rx channel control 2
	output logic      [2:0]  status_out,       // Empty, full, underrun
	output logic      [7:0]  fifo_data_out,    // Byte popped from FIFO
	output logic             send_start_out    // Code word send start pulse
);
	localparam int CW = $clog2(DEPTH + 1);
	localparam int PW = $clog2(DEPTH);

	logic [7:0]    mem_r [DEPTH];
	logic [PW-1:0] wptr_r;
	logic [PW-1:0] rptr_r;
	logic [CW-1:0] count_r;
	logic          udr_r;
	logic          full;
	logic          empty;
	logic          push;
	logic          pop;

	assign full  = (count_r == CW'(DEPTH));
	assign empty = (count_r == '0);
	assign push  = wr_fifo_in && !full;
	assign pop   = fifo_pop_in && !empty;
	assign status_out = {empty, full, udr_r};

	// ------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			code_ctl_out   <= HCW_CODE_RST;
			rdc1_out       <= HCW_RDC1_RST;
			rdc2_out       <= HCW_RDC2_RST;
			send_start_out <= 1'b0;
		end else begin
			// Only a 0 to 1 change of the send bit starts a code word
			send_start_out <= wr_code_in && wdata_in[HCW_SEND_BIT]
				&& !code_ctl_out[HCW_SEND_BIT];
			if (wr_code_in)
				code_ctl_out <= wdata_in;
			if (wr_rdc1_in)
				rdc1_out <= wdata_in;
			if (wr_rdc2_in)
				rdc2_out <= wdata_in;
		end
	end

	// ------------------------------------------------------------
	// Transmit FIFO
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk_in) begin
		if (push)
			mem_r[wptr_r] <= wdata_in;
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wptr_r        <= '0;
			rptr_r        <= '0;
			count_r       <= '0;
			fifo_data_out <= 8'h00;
		end else begin
			if (push)
				wptr_r <= (wptr_r == PW'(DEPTH - 1)) ? '0 : wptr_r + 1'b1;
			if (pop) begin
				rptr_r        <= (rptr_r == PW'(DEPTH - 1)) ? '0 : rptr_r + 1'b1;
				fifo_data_out <= mem_r[rptr_r];
			end
			count_r <= count_r + CW'(push) - CW'(pop);
		end
	end

	// Set beats the read clear so an underrun in the read cycle survives
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			udr_r <= 1'b0;
		else if (fifo_pop_in && empty)
			udr_r <= 1'b1;
		else if (rd_stat_in)
			udr_r <= 1'b0;
	end

	a_full_blocks_push: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		(full && wr_fifo_in && !fifo_pop_in) |=> (count_r == CW'(DEPTH)) && status_out[1])
		else $error("write to full FIFO changed its fill");
	a_udr_sticky: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		(udr_r && !rd_stat_in) |=> udr_r)
		else $error("underrun flag dropped without a status read");
	a_udr_set: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		(fifo_pop_in && empty) |=> status_out[0])
		else $error("underrun not flagged on pop from empty FIFO");
	c_fifo_full: cover property (@(posedge sys_clk_in) disable iff (!rst_n_in) full);
endmodule : hcw_framer

// [verification/hcw_hdlc_model.sv]
//------------------------------------------------------------
// Purpose: Transmit HDLC controller side facing the control bank
// Assumes: Bench asks for pops and link levels one cycle ahead
// Notes:   Pops are registered, so they never share an edge with a request
//------------------------------------------------------------
module hcw_hdlc_model
	import hcw_pkg::*;
(
	input  wire logic       sys_clk_in,       // System clock
	input  wire logic       rst_n_in,         // Async reset, active low
	input  wire logic [1:0] pop_req_in,       // Bench asks for one byte
	input  wire logic [1:0] fdl_level_in,     // Link bit to present
	output logic      [1:0] fifo_pop_out,     // Byte take pulse
	output logic      [1:0] hdlc_fdl_bit_out  // On-chip link bit
);
	timeunit 1ns;
	timeprecision 1ns;
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			fifo_pop_out     <= 2'h0;
			hdlc_fdl_bit_out <= 2'h0;
		end else begin
			fifo_pop_out     <= pop_req_in;
			hdlc_fdl_bit_out <= fdl_level_in;
		end
	end
endmodule : hcw_hdlc_model

// [verification/testbench.sv]
//------------------------------------------------------------
// Purpose: Self-checking bench for the code word and channel bank
// Assumes: FIFO depth cut to 4 so fill and drain stay short
// Notes:   Read data is sampled two edges late; it holds until the next read
//------------------------------------------------------------
module testbench
	import hcw_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int FD = 4;
	logic        sys_clk_in, rst_n_in, bus_wr, bus_rd;
	logic [7:0]  bus_addr, bus_wdata, bus_rdata;
	logic [1:0]  link_pin, pop_req, fdl_level, fifo_pop, hdlc_bit, fifo_empty;
	logic [1:0]  fdl_bit, send_pulse, rx_en, rx_mode;
	logic [15:0] fifo_data, rx_supp;
	logic [11:0] code_word;
	logic [9:0]  rx_sel;
	logic [31:0] seed = 32'h00012902;
	int          fail_count, checked;
	int          pulses[2] = '{0, 0};

	hcw_ctl #(.FIFO_DEPTH(FD)) dut_u (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
		.bus_addr_in(bus_addr), .bus_wr_in(bus_wr), .bus_rd_in(bus_rd),
		.bus_wdata_in(bus_wdata), .bus_rdata_out(bus_rdata),
		.tx_link_input_pin_in(link_pin), .hdlc_fdl_bit_in(hdlc_bit),
		.fifo_pop_in(fifo_pop), .fifo_data_out(fifo_data), .fifo_empty_out(fifo_empty),
		.fdl_bit_out(fdl_bit), .send_code_word_out(send_pulse), .code_word_out(code_word),
		.rx_channel_enable_out(rx_en), .rx_channel_select_mode_out(rx_mode),
		.rx_chan_sel_out(rx_sel), .rx_bit_suppress_out(rx_supp));
	hcw_hdlc_model hdlc_u (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
		.pop_req_in(pop_req), .fdl_level_in(fdl_level), .fifo_pop_out(fifo_pop),
		.hdlc_fdl_bit_out(hdlc_bit));

	// ------------------------------------------------------------
	// Clock, pulse counting, helpers
	// ------------------------------------------------------------
	initial begin
		sys_clk_in = 1'b0;
		forever #50 sys_clk_in = ~sys_clk_in;
	end
	always @(posedge sys_clk_in) begin
		for (int f = 0; f < 2; f++) if (send_pulse[f] === 1'b1) pulses[f]++;
	end
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs
	function automatic logic [7:0] off(input int f, input logic [7:0] a, input logic [7:0] b);
		return (f != 0) ? b : a;
	endfunction : off
	function automatic logic [7:0] stat(input logic e, input logic fl, input logic u);
		return {5'h00, e, fl, u};
	endfunction : stat
	task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : check
	task automatic bus_write(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk_in);
		bus_addr  <= a;
		bus_wdata <= d;
		bus_wr    <= 1'b1;
		@(posedge sys_clk_in);
		bus_wr    <= 1'b0;
	endtask : bus_write
	task automatic rd_check(input logic [7:0] a, input logic [7:0] exp, input string what);
		@(posedge sys_clk_in);
		bus_addr <= a;
		bus_rd   <= 1'b1;
		@(posedge sys_clk_in);
		bus_rd   <= 1'b0;
		@(posedge sys_clk_in);
		@(negedge sys_clk_in);
		check(16'(bus_rdata), 16'(exp), what);
	endtask : rd_check
	task automatic pop(input int f);
		@(posedge sys_clk_in);
		pop_req <= 2'(1 << f);
		@(posedge sys_clk_in);
		pop_req <= 2'h0;
		repeat (3) @(posedge sys_clk_in);
		@(negedge sys_clk_in);
	endtask : pop
	task automatic conclude();
		$display("checks made %0d, mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : conclude

	// ------------------------------------------------------------
	// Watchdog: whole run needs well under a thousand cycles
	// ------------------------------------------------------------
	initial begin
		repeat (20000) @(posedge sys_clk_in);
		fail_count++;
		conclude();
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		logic [31:0] v;
		logic [7:0]  d[FD+1];
		int          n;
		{rst_n_in, bus_wr, bus_rd, bus_addr, bus_wdata} = '0;
		{link_pin, pop_req, fdl_level} = '0;
		repeat (20) @(posedge sys_clk_in);
		rst_n_in <= 1'b1;
		@(posedge sys_clk_in);
		bus_write(8'h33, 8'hff);
		rd_check(8'h33, 8'h00, "unmapped");
		for (int f = 0; f < 2; f++) begin
			rd_check(off(f, HCW_CODE_A_OFF, HCW_CODE_B_OFF), HCW_CODE_RST, "code rst");
			rd_check(off(f, HCW_STAT_A_OFF, HCW_STAT_B_OFF), stat(1, 0, 0), "stat rst");
			rd_check(off(f, HCW_FIFO_A_OFF, HCW_FIFO_B_OFF), 8'h00, "fifo reg");
			for (int i = 0; i < 6; i++) begin
				v = xs() & 32'hffbf;
				bus_write(off(f, HCW_RDC1_A_OFF, HCW_RDC1_B_OFF), v[7:0]);
				bus_write(off(f, HCW_RDC2_A_OFF, HCW_RDC2_B_OFF), v[15:8]);
				@(negedge sys_clk_in);
				check(16'(rx_sel[f*5 +: 5]), 16'(v[4:0]), "chan sel");
				check(16'(rx_en[f]), 16'(v[7]), "chan enable");
				check(16'(rx_mode[f]), 16'(v[5]), "sel mode");
				check(16'(rx_supp[f*8 +: 8]), 16'(v[15:8]), "suppress");
				rd_check(off(f, HCW_RDC1_A_OFF, HCW_RDC1_B_OFF), v[7:0], "ctl1 back");
				rd_check(off(f, HCW_RDC2_A_OFF, HCW_RDC2_B_OFF), v[15:8], "ctl2 back");
			end
			// Send pulse only on a 0 to 1 change, never on a repeated 1
			for (int i = 0; i < 4; i++) begin
				v = xs();
				bus_write(off(f, HCW_CODE_A_OFF, HCW_CODE_B_OFF), {1'b0, v[6:0]});
				n = pulses[f];
				bus_write(off(f, HCW_CODE_A_OFF, HCW_CODE_B_OFF), {1'b1, v[6:0]});
				bus_write(off(f, HCW_CODE_A_OFF, HCW_CODE_B_OFF), {1'b1, v[6:0]});
				repeat (2) @(posedge sys_clk_in);
				@(negedge sys_clk_in);
				check(16'(pulses[f]), 16'(n + 1), "send pulses");
				check(16'(code_word[f*6 +: 6]), 16'(v[5:0]), "code word");
				rd_check(off(f, HCW_CODE_A_OFF, HCW_CODE_B_OFF), {1'b1, v[6:0]}, "code back");
				bus_write(off(f, HCW_CODE_A_OFF, HCW_CODE_B_OFF), {2'b00, v[5:0]});
				@(posedge sys_clk_in);
				link_pin  <= v[9:8];
				fdl_level <= v[11:10];
				repeat (5) @(posedge sys_clk_in);
				@(negedge sys_clk_in);
				check(16'(fdl_bit[f]), 16'(v[8+f]), "pin source");
				bus_write(off(f, HCW_CODE_A_OFF, HCW_CODE_B_OFF), {2'b01, v[5:0]});
				repeat (3) @(posedge sys_clk_in);
				@(negedge sys_clk_in);
				check(16'(fdl_bit[f]), 16'(v[10+f]), "hdlc source");
			end
			// Fill past full: the extra byte must be dropped
			for (int i = 0; i <= FD; i++) begin
				v = xs();
				d[i] = v[7:0];
				bus_write(off(f, HCW_FIFO_A_OFF, HCW_FIFO_B_OFF), d[i]);
			end
			rd_check(off(f, HCW_STAT_A_OFF, HCW_STAT_B_OFF), stat(0, 1, 0), "full");
			for (int i = 0; i < FD; i++) begin
				pop(f);
				check(16'(fifo_data[f*8 +: 8]), 16'(d[i]), "pop data");
				check(16'(fifo_empty[f]), 16'(i == FD - 1), "empty flag");
				if (i == 0) rd_check(off(f, HCW_STAT_A_OFF, HCW_STAT_B_OFF), stat(0, 0, 0), "room");
			end
			pop(f);
			check(16'(fifo_data[f*8 +: 8]), 16'(d[FD-1]), "empty pop");
			rd_check(off(f, HCW_STAT_A_OFF, HCW_STAT_B_OFF), stat(1, 0, 1), "underrun");
			rd_check(off(f, HCW_STAT_A_OFF, HCW_STAT_B_OFF), stat(1, 0, 0), "cleared");
		end
		conclude();
	end
endmodule : testbench
